// ==== rtl/bbsr_map.svh ====
`ifndef BBSR_MAP_SVH
`define BBSR_MAP_SVH
`define BBSR_STAGES 8
`define BBSR_RESET_VAL 8'h00
`endif

// ==== rtl/bbsr_pkg.sv ====
`default_nettype none
`include "bbsr_map.svh"
package bbsr_pkg;
    typedef logic [`BBSR_STAGES-1:0] bbsr_word_t;
    typedef enum logic [1:0] {
        BBSR_HOLD  = 2'b00,
        BBSR_SHIFT = 2'b01,
        BBSR_SYNC  = 2'b10,
        BBSR_ASYNC = 2'b11
    } bbsr_mode_e;
    typedef struct packed {
        bbsr_word_t stage;
        logic       clk_dly;
    } bbsr_state_s;
endpackage
`default_nettype wire

// ==== rtl/bbsr_stage.sv ====
`default_nettype none
// one master-slave stage: the next value settles combinationally (master),
// the register takes it only on a load (slave), so a held stage never moves
module bbsr_stage #(
    parameter logic reset_val = 1'b0
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // load control and data
    input  wire logic load_i,
    input  wire logic d_i,
    output var  logic q_o
);
    typedef struct packed {
        logic q;
    } bbsr_stage_s;

    bbsr_stage_s st_ff;
    bbsr_stage_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (load_i) begin
            nxt_st.q = d_i; // [RULE7]
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_ff <= '{q: reset_val};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_o = st_ff.q;
endmodule
`default_nettype wire

// ==== rtl/bbsr_top.sv ====
`default_nettype none
`include "bbsr_map.svh"
// Functional notes
// (RULE1) eight stages loaded parallel or serially, contents shown in parallel
// (RULE2) sixteen two-way data lines, eight per side, one side in, other out
// (RULE3) direction high: A in, B driven; low: B in, A driven
// (RULE4) parallel mode, sync: load input side on shift clock rising edge
// (RULE5) parallel mode, async: load input side without waiting for a clock edge
// (RULE6) one serial data input for serial-to-parallel conversion
// (RULE7) each stage is master-slave with internally made clocks
// (RULE8) outside logic runs it with one clock, direction and mode selects
// (RULE9) an enable input gates parallel entry from the A lines
// (RULE10) transfer, serial-to-parallel, recirculate, parallel-to-serial uses
// (RULE11) outputs are buffered so loading cannot disturb stored state
// (RULE12) serial mode: each rising edge shifts serial input into stage one
// (RULE13) A side selected as input with enable low: no load from A
module bbsr_top
    import bbsr_pkg::*;
(
    // clock and reset
    input  wire logic       SYS_CLK_I,
    input  wire logic       RESET_I,
    // control
    input  wire logic       SHIFT_CLOCK_I,
    input  wire logic       A_TO_B_I,
    input  wire logic       PARALLEL_I,
    input  wire logic       ASYNC_LOAD_I,
    input  wire logic       A_SIDE_INPUT_ENABLE_I,
    input  wire logic       SERIAL_I,
    // A side lines
    input  wire logic [7:0] A_DATA_I,
    output logic      [7:0] A_DATA_O,
    output logic            A_DATA_OE_O,
    // B side lines
    input  wire logic [7:0] B_DATA_I,
    output logic      [7:0] B_DATA_O,
    output logic            B_DATA_OE_O,
    // parallel contents and serial end
    output logic      [7:0] Q_O,
    output logic            SERIAL_O
);
    localparam bbsr_word_t rst_word = `BBSR_RESET_VAL;

    // registered state: output copy of the stages and shift clock history
    bbsr_state_s st_ff;
    bbsr_state_s nxt_st;

    // control decode
    bbsr_mode_e  mode;
    logic        rise;
    logic        a_is_input;
    logic        par_allowed;
    logic        async_req;
    logic        sync_req;
    logic        shift_req;
    logic        ld;

    // data paths
    bbsr_word_t  in_word;
    bbsr_word_t  shift_word;
    bbsr_word_t  d_word;
    bbsr_word_t  q_word;

    // the shift clock is a sampled level; its history resets low, so a clock
    // already high when reset lets go counts as one rise
    assign rise = SHIFT_CLOCK_I & ~st_ff.clk_dly; // [RULE8]

    // direction picks which side feeds the stages
    assign a_is_input = A_TO_B_I; // [RULE3]

    always_comb begin
        case (a_is_input)
            1'b1: begin
                in_word = A_DATA_I; // [RULE3]
            end
            1'b0: begin
                in_word = B_DATA_I; // [RULE3]
            end
            default: begin
                in_word = B_DATA_I;
            end
        endcase
    end

    // the enable qualifies the A lines only; B-side entry is never gated
    assign par_allowed = ~a_is_input | A_SIDE_INPUT_ENABLE_I; // [RULE9] [RULE13]

    // async entry is level-true, caught at every system clock (one-cycle latency)
    assign async_req = PARALLEL_I & ASYNC_LOAD_I & par_allowed; // [RULE5]
    assign sync_req  = PARALLEL_I & ~ASYNC_LOAD_I & par_allowed & rise; // [RULE4]
    assign shift_req = ~PARALLEL_I & rise; // [RULE12]

    always_comb begin
        mode = BBSR_HOLD;
        if (async_req) begin
            mode = BBSR_ASYNC;
        end else if (sync_req) begin
            mode = BBSR_SYNC;
        end else if (shift_req) begin
            mode = BBSR_SHIFT;
        end
    end

    // stage 0 takes the serial input, each later stage its lower neighbour
    assign shift_word = {q_word[`BBSR_STAGES-2:0], SERIAL_I}; // [RULE6] [RULE12]

    // a refused or idle cycle keeps every stage as it is
    always_comb begin
        d_word = q_word;
        ld     = 1'b0;
        case (mode)
            BBSR_SHIFT: begin
                d_word = shift_word; // [RULE12]
                ld     = 1'b1;
            end
            BBSR_SYNC,
            BBSR_ASYNC: begin
                d_word = in_word; // [RULE10]
                ld     = 1'b1;
            end
            BBSR_HOLD: begin
                d_word = q_word;
                ld     = 1'b0;
            end
            default: begin
                d_word = q_word;
                ld     = 1'b0;
            end
        endcase
    end

    // all eight stages share one load strobe, so a word enters them together
    bbsr_stage #(
        .reset_val (rst_word[0])
    ) u_stage_0 ( // [RULE1] [RULE7]
        .clk_i   (SYS_CLK_I),
        .reset_i (RESET_I),
        .load_i  (ld),
        .d_i     (d_word[0]),
        .q_o     (q_word[0])
    );

    bbsr_stage #(
        .reset_val (rst_word[1])
    ) u_stage_1 ( // [RULE1] [RULE7]
        .clk_i   (SYS_CLK_I),
        .reset_i (RESET_I),
        .load_i  (ld),
        .d_i     (d_word[1]),
        .q_o     (q_word[1])
    );

    bbsr_stage #(
        .reset_val (rst_word[2])
    ) u_stage_2 ( // [RULE1] [RULE7]
        .clk_i   (SYS_CLK_I),
        .reset_i (RESET_I),
        .load_i  (ld),
        .d_i     (d_word[2]),
        .q_o     (q_word[2])
    );

    bbsr_stage #(
        .reset_val (rst_word[3])
    ) u_stage_3 ( // [RULE1] [RULE7]
        .clk_i   (SYS_CLK_I),
        .reset_i (RESET_I),
        .load_i  (ld),
        .d_i     (d_word[3]),
        .q_o     (q_word[3])
    );

    bbsr_stage #(
        .reset_val (rst_word[4])
    ) u_stage_4 ( // [RULE1] [RULE7]
        .clk_i   (SYS_CLK_I),
        .reset_i (RESET_I),
        .load_i  (ld),
        .d_i     (d_word[4]),
        .q_o     (q_word[4])
    );

    bbsr_stage #(
        .reset_val (rst_word[5])
    ) u_stage_5 ( // [RULE1] [RULE7]
        .clk_i   (SYS_CLK_I),
        .reset_i (RESET_I),
        .load_i  (ld),
        .d_i     (d_word[5]),
        .q_o     (q_word[5])
    );

    bbsr_stage #(
        .reset_val (rst_word[6])
    ) u_stage_6 ( // [RULE1] [RULE7]
        .clk_i   (SYS_CLK_I),
        .reset_i (RESET_I),
        .load_i  (ld),
        .d_i     (d_word[6]),
        .q_o     (q_word[6])
    );

    bbsr_stage #(
        .reset_val (rst_word[7])
    ) u_stage_7 ( // [RULE1] [RULE7]
        .clk_i   (SYS_CLK_I),
        .reset_i (RESET_I),
        .load_i  (ld),
        .d_i     (d_word[7]),
        .q_o     (q_word[7])
    );

    // output copy follows the stages on the same edge
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.clk_dly = SHIFT_CLOCK_I; // [RULE8]
        nxt_st.stage   = d_word; // [RULE11]
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            st_ff <= '{stage: rst_word, clk_dly: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // A, B and serial pins read the separate copy, so bus loading stays apart; Q_O reads the stages
    assign A_DATA_O = st_ff.stage; // [RULE11]
    assign B_DATA_O = st_ff.stage; // [RULE11]
    assign Q_O      = q_word; // [RULE1]
    assign SERIAL_O = st_ff.stage[`BBSR_STAGES-1]; // [RULE10]

    // exactly one side drives at a time; the other is the input side
    always_comb begin
        case (a_is_input)
            1'b1: begin
                A_DATA_OE_O = 1'b0; // [RULE2] [RULE3]
                B_DATA_OE_O = 1'b1; // [RULE2] [RULE3]
            end
            1'b0: begin
                A_DATA_OE_O = 1'b1;
                B_DATA_OE_O = 1'b0;
            end
            default: begin
                A_DATA_OE_O = 1'b0;
                B_DATA_OE_O = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ==== tb/bbsr_top_asserts.sv ====
`default_nettype none
module bbsr_top_asserts (
    // clock and reset
    input wire logic       SYS_CLK_I,
    input wire logic       RESET_I,
    // control
    input wire logic       SHIFT_CLOCK_I,
    input wire logic       A_TO_B_I,
    input wire logic       PARALLEL_I,
    input wire logic       ASYNC_LOAD_I,
    input wire logic       A_SIDE_INPUT_ENABLE_I,
    input wire logic       SERIAL_I,
    // data lines and enables
    input wire logic [7:0] A_DATA_I,
    input wire logic [7:0] A_DATA_O,
    input wire logic       A_DATA_OE_O,
    input wire logic [7:0] B_DATA_I,
    input wire logic [7:0] B_DATA_O,
    input wire logic       B_DATA_OE_O,
    // contents
    input wire logic [7:0] Q_O,
    input wire logic       SERIAL_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       prv_ff;
    wire        rise = SHIFT_CLOCK_I & ~prv_ff;
    wire        gate = ~A_TO_B_I | A_SIDE_INPUT_ENABLE_I;
    wire  [7:0] din  = A_TO_B_I ? A_DATA_I : B_DATA_I;
    wire        ld   = PARALLEL_I & (ASYNC_LOAD_I | rise) & gate;
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            prv_ff <= 1'h0;
        end else begin
            prv_ff <= SHIFT_CLOCK_I;
        end
    end
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    a_sync_load: assert property (PARALLEL_I & ~ASYNC_LOAD_I & rise & gate
        |=> Q_O == $past(din)) else $error("sync load");
    a_async_load: assert property (PARALLEL_I & ASYNC_LOAD_I & gate
        |=> Q_O == $past(din)) else $error("async load");
    a_serial_shift: assert property (~PARALLEL_I & rise
        |=> Q_O == {$past(Q_O[6:0]), $past(SERIAL_I)}) else $error("shift");
    a_hold_state: assert property (~ld & ~(~PARALLEL_I & rise)
        |=> $stable(Q_O)) else $error("hold");
    a_enable_gate: assert property (A_TO_B_I & ~A_SIDE_INPUT_ENABLE_I & PARALLEL_I
        |=> $stable(Q_O)) else $error("enable");
    a_dir_enables: assert property (B_DATA_OE_O == A_TO_B_I && A_DATA_OE_O != A_TO_B_I)
        else $error("direction");
    a_out_buffer: assert property (A_DATA_O == Q_O && B_DATA_O == Q_O)
        else $error("outputs");
    a_serial_end: assert property (SERIAL_O == Q_O[7]) else $error("serial out");
    a_b_side_entry: assert property (~A_TO_B_I & ~A_SIDE_INPUT_ENABLE_I & PARALLEL_I
        & ASYNC_LOAD_I |=> Q_O == $past(B_DATA_I)) else $error("b side entry");
endmodule
bind bbsr_top bbsr_top_asserts bbsr_top_asserts_i (
    .SYS_CLK_I             (SYS_CLK_I),
    .RESET_I               (RESET_I),
    .SHIFT_CLOCK_I         (SHIFT_CLOCK_I),
    .A_TO_B_I              (A_TO_B_I),
    .PARALLEL_I            (PARALLEL_I),
    .ASYNC_LOAD_I          (ASYNC_LOAD_I),
    .A_SIDE_INPUT_ENABLE_I (A_SIDE_INPUT_ENABLE_I),
    .SERIAL_I              (SERIAL_I),
    .A_DATA_I              (A_DATA_I),
    .A_DATA_O              (A_DATA_O),
    .A_DATA_OE_O           (A_DATA_OE_O),
    .B_DATA_I              (B_DATA_I),
    .B_DATA_O              (B_DATA_O),
    .B_DATA_OE_O           (B_DATA_OE_O),
    .Q_O                   (Q_O),
    .SERIAL_O              (SERIAL_O)
);
`default_nettype wire

// ==== tb/bbsr_bus_model.sv ====
`default_nettype none
module bbsr_bus_model (
    // enables from the block
    input  wire logic       a_oe_i,
    input  wire logic       b_oe_i,
    // words on offer
    input  wire logic [7:0] a_dev_i,
    input  wire logic [7:0] b_dev_i,
    input  wire logic [7:0] word_i,
    // pin levels seen by the block
    output logic      [7:0] a_pin_o,
    output logic      [7:0] b_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // each pin level from the block's enable for that side only; bus drives the undriven side
    assign a_pin_o = a_oe_i ? a_dev_i : word_i;
    assign b_pin_o = b_oe_i ? b_dev_i : word_i;
endmodule
`default_nettype wire

// ==== tb/tb_bbsr_top.sv ====
`default_nettype none
module tb_bbsr_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic SYS_CLK_I = 0, RESET_I = 1, SHIFT_CLOCK_I = 0, A_TO_B_I = 0, PARALLEL_I = 0;
    logic ASYNC_LOAD_I = 0, A_SIDE_INPUT_ENABLE_I = 0, SERIAL_I = 0;
    logic A_DATA_OE_O, B_DATA_OE_O, SERIAL_O;
    logic [7:0] word = 0, A_DATA_I, B_DATA_I, A_DATA_O, B_DATA_O, Q_O;
    logic [26:0] got, want;
    int   seed = 31876, miscompares = 0, compares = 0, cyc = 0, exp = 0, r;
    bit   prv;
    always #12.5 SYS_CLK_I = ~SYS_CLK_I;
    bbsr_top bbsr_top_i (
        .SYS_CLK_I             (SYS_CLK_I),
        .RESET_I               (RESET_I),
        .SHIFT_CLOCK_I         (SHIFT_CLOCK_I),
        .A_TO_B_I              (A_TO_B_I),
        .PARALLEL_I            (PARALLEL_I),
        .ASYNC_LOAD_I          (ASYNC_LOAD_I),
        .A_SIDE_INPUT_ENABLE_I (A_SIDE_INPUT_ENABLE_I),
        .SERIAL_I              (SERIAL_I),
        .A_DATA_I              (A_DATA_I),
        .A_DATA_O              (A_DATA_O),
        .A_DATA_OE_O           (A_DATA_OE_O),
        .B_DATA_I              (B_DATA_I),
        .B_DATA_O              (B_DATA_O),
        .B_DATA_OE_O           (B_DATA_OE_O),
        .Q_O                   (Q_O),
        .SERIAL_O              (SERIAL_O)
    );
    bbsr_bus_model bbsr_bus_model_i (.a_oe_i(A_DATA_OE_O), .b_oe_i(B_DATA_OE_O),
        .a_dev_i(A_DATA_O), .b_dev_i(B_DATA_O), .word_i(word),
        .a_pin_o(A_DATA_I), .b_pin_o(B_DATA_I));
    task automatic finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge SYS_CLK_I) if (++cyc > 700) begin
        miscompares++;
        finish_test;
    end
    initial begin
        repeat (10) @(negedge SYS_CLK_I);
        RESET_I = 0;
        repeat (500) begin
            @(negedge SYS_CLK_I);
            compares++;
            got  = {Q_O, A_DATA_O, B_DATA_O, SERIAL_O, A_DATA_OE_O, B_DATA_OE_O};
            want = {exp[7:0], exp[7:0], exp[7:0], exp[7], !A_TO_B_I, A_TO_B_I};
            if (got !== want) begin
                miscompares++;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
            end
            // second reset mid-run: contents and shift clock history clear
            RESET_I = (compares == 250);
            if (RESET_I) begin
                exp = 0;
                prv = 0;
            end else begin
                r = $random(seed);
                {SHIFT_CLOCK_I, A_TO_B_I, PARALLEL_I, ASYNC_LOAD_I} = r[13:10];
                {A_SIDE_INPUT_ENABLE_I, SERIAL_I, word} = r[9:0];
                if (PARALLEL_I && (ASYNC_LOAD_I || SHIFT_CLOCK_I && !prv)
                    && (!A_TO_B_I || A_SIDE_INPUT_ENABLE_I)) exp = word;
                else if (!PARALLEL_I && SHIFT_CLOCK_I && !prv)
                    exp = {exp[6:0], SERIAL_I};
                prv = SHIFT_CLOCK_I;
            end
        end
        finish_test;
    end
endmodule
`default_nettype wire
